// ==== verilog/bmvc_top.sv ====
// Mode, set-point and current-limit control for two identical buck converters
//
// Contract
// R1 - Fuse bit 0 enables scaling, 1 disables
// R2 - Disabled scaling uses fixed soft-start reference
// R3 - Conduction mode follows load, bits and states
// R4 - Off mode stops switching, discharges output
// R5 - Adaptive mode is the default
// R6 - Forced PWM never skips pulses
// R7 - Low-power only in standby or sleep
// R8 - All modes available for both fuse values
// R9 - Enable low disables in every state
// R10 - Force-PWM bit overrides low-power bit
// R11 - Run ignores low-power request
// R12 - Standby bit gates; low-power mode allowed
// R13 - Sleep bit gates; adaptive by default
// R14 - High and low side limits, per cycle
// R15 - Over-limit switch off for rest of cycle
// R16 - Limit hit sets sense bit at once
// R17 - Status set after 8 ms persistence
// R18 - Start-up copies fused code to all fields
// R19 - Host rewrites fields after start-up with scaling
// R20 - Fields read-only when scaling disabled
// R21 - Scaling code linear, 12.5 mV per step
// R22 - Fixed table, codes above seven give 3.3 V
// R23 - Ramp one step per 2 or 4 us
// R24 - Optional forced PWM on falling ramp
// R25 - Mode re-evaluated within one clock
// R26 - Debounce restarts when fault clears early
`default_nettype none
module bmvc_top
  import bmvc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input  wire logic                         core_clk,
  input  wire logic                         nrst,
  input  wire bmvc_pkg::bmvc_pstate_t       power_state,
  input  wire logic                         processor_reset_out,
  input  wire logic [1:0]                   scaling_disable_fuse,
  input  wire logic [1:0][5:0]              fused_setpoint_code,
  input  wire bmvc_pkg::bmvc_ctrl_t [1:0]   ctrl,
  input  wire bmvc_pkg::bmvc_spwr_t [1:0]   setpoint_write,
  input  wire logic [1:0]                   hs_over_limit,
  input  wire logic [1:0]                   ls_over_limit,
  input  wire logic [1:0]                   cycle_start,
  output logic [1:0][5:0]                   run_setpoint_code,
  output logic [1:0][5:0]                   standby_setpoint_code,
  output logic [1:0][5:0]                   sleep_setpoint_code,
  output bmvc_pkg::bmvc_drive_t [1:0]       drive,
  output logic [1:0]                        hs_limit_sense,
  output logic [1:0]                        ls_limit_sense,
  output logic [1:0]                        hs_limit_status,
  output logic [1:0]                        ls_limit_status
);
  import bmvc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up detection and pin synchronisers
  bmvc_pstate_t ps_prev_ff;
  logic         rst_meta_ff;
  logic         rst_sync_ff;
  logic [1:0]   hs_meta_ff;
  logic [1:0]   hs_sync_ff;
  logic [1:0]   ls_meta_ff;
  logic [1:0]   ls_sync_ff;
  logic [1:0]   cs_meta_ff;
  logic [1:0]   cs_sync_ff;
  wire          startup = (ps_prev_ff == PS_REGS_OFF) && (power_state == PS_RUN);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ps_prev_ff  <= PS_REGS_OFF;
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
      hs_meta_ff  <= 2'h0;
      hs_sync_ff  <= 2'h0;
      ls_meta_ff  <= 2'h0;
      ls_sync_ff  <= 2'h0;
      cs_meta_ff  <= 2'h0;
      cs_sync_ff  <= 2'h0;
    end else begin
      ps_prev_ff  <= power_state;
      rst_meta_ff <= processor_reset_out;
      rst_sync_ff <= rst_meta_ff;
      hs_meta_ff  <= hs_over_limit;
      hs_sync_ff  <= hs_meta_ff;
      ls_meta_ff  <= ls_over_limit;
      ls_sync_ff  <= ls_meta_ff;
      cs_meta_ff  <= cycle_start;
      cs_sync_ff  <= cs_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per converter logic
  for (genvar g = 0; g < NUM_BUCKS; g++) begin : g_buck
    bmvc_ctrl_t c;
    bmvc_mode_t nxt_mode;
    bmvc_mode_t mode_ff;
    logic [5:0] run_ff;
    logic [5:0] stby_ff;
    logic [5:0] slp_ff;
    logic [5:0] ramp_ff;
    logic [5:0] target;
    logic [9:0] step_ff;
    logic       hs_off_ff;
    logic       ls_off_ff;
    logic       hs_sense_ff;
    logic       ls_sense_ff;
    logic       hs_stat_ff;
    logic       ls_stat_ff;
    logic [CNT_W-1:0] hs_cnt_ff;
    logic [CNT_W-1:0] ls_cnt_ff;
    wire        scale_on = ~scaling_disable_fuse[g];                            // [R1]
    // Host may write only once start-up is over; fields stay fused otherwise
    wire        host_ok  = scale_on && rst_sync_ff && !startup;                 // [R19] [R20]
    // Slow step needs 800 cycles, so the counter is ten bits wide
    wire [9:0]  step_len = c.scaling_step_rate ? 10'(STEP_SLOW_CYC)
                                               : 10'(STEP_FAST_CYC);            // [R23]
    wire        step_due = (step_ff >= step_len - 10'h001);
    wire        falling  = scale_on && (ramp_ff > target);
    wire        ramp_pwm = falling && c.pwm_during_falling_ramp;                // [R24]
    wire        lp_ok    = c.buck_low_power_request && !c.buck_force_pwm;

    assign c = ctrl[g];

    // Mode table; identical for both fuse values
    always_comb begin                                                           // [R8] [R25]
      nxt_mode = MODE_ADAPTIVE;                                                 // [R5]
      case (power_state)
        PS_RUN:     nxt_mode = c.buck_force_pwm ? MODE_FPWM : MODE_ADAPTIVE;    // [R11]
        PS_STANDBY: if (!c.buck_on_in_standby) begin
                      nxt_mode = MODE_OFF;                                      // [R12]
                    end else if (lp_ok) begin
                      nxt_mode = MODE_LOW_POWER;                                // [R7] [R12]
                    end else begin
                      nxt_mode = c.buck_force_pwm ? MODE_FPWM : MODE_ADAPTIVE;
                    end
        PS_SLEEP:   if (!c.buck_on_in_sleep) begin
                      nxt_mode = MODE_OFF;                                      // [R13]
                    end else if (lp_ok) begin
                      nxt_mode = MODE_LOW_POWER;                                // [R7]
                    end else begin
                      nxt_mode = c.buck_force_pwm ? MODE_FPWM : MODE_ADAPTIVE;  // [R10] [R13]
                    end
        default:    nxt_mode = MODE_OFF;
      endcase
      if (!c.buck_enable) begin
        nxt_mode = MODE_OFF;                                                    // [R9]
      end else if (ramp_pwm && nxt_mode != MODE_OFF) begin
        nxt_mode = MODE_FPWM;                                                   // [R24]
      end
    end

    always_comb begin
      case (power_state)
        PS_STANDBY: target = stby_ff;
        PS_SLEEP:   target = slp_ff;
        default:    target = run_ff;
      endcase
    end

    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        mode_ff <= MODE_OFF;
        run_ff  <= CODE_RST;
        stby_ff <= CODE_RST;
        slp_ff  <= CODE_RST;
      end else begin
        mode_ff <= nxt_mode;                                                    // [R3] [R25]
        if (startup) begin
          run_ff  <= fused_setpoint_code[g];                                    // [R18]
          stby_ff <= fused_setpoint_code[g];
          slp_ff  <= fused_setpoint_code[g];
        end else if (host_ok) begin
          if (setpoint_write[g].run_we) run_ff <= setpoint_write[g].data;       // [R19]
          if (setpoint_write[g].standby_we) stby_ff <= setpoint_write[g].data;
          if (setpoint_write[g].sleep_we) slp_ff <= setpoint_write[g].data;
        end
      end
    end

    // Ramp walks one code per step period toward the target
    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        ramp_ff <= CODE_RST;
        step_ff <= 10'h000;
      end else if (!scale_on || startup || ramp_ff == target) begin
        ramp_ff <= target;
        step_ff <= 10'h000;
      end else if (step_due) begin
        ramp_ff <= falling ? ramp_ff - 6'h01 : ramp_ff + 6'h01;                 // [R21] [R23]
        step_ff <= 10'h000;
      end else begin
        step_ff <= step_ff + 10'h001;
      end
    end

    // Gate stays off until the next switching cycle begins
    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        hs_off_ff <= 1'b0;
        ls_off_ff <= 1'b0;
      end else begin
        hs_off_ff <= hs_sync_ff[g] | (hs_off_ff & ~cs_sync_ff[g]);              // [R14] [R15]
        ls_off_ff <= ls_sync_ff[g] | (ls_off_ff & ~cs_sync_ff[g]);              // [R14] [R15]
      end
    end

    // Sense follows the limit; status needs an unbroken debounce window
    always_ff @(posedge core_clk) begin
      if (!nrst) begin
        hs_sense_ff <= 1'b0;
        ls_sense_ff <= 1'b0;
        hs_stat_ff  <= 1'b0;
        ls_stat_ff  <= 1'b0;
        hs_cnt_ff   <= '0;
        ls_cnt_ff   <= '0;
      end else begin
        hs_sense_ff <= hs_sync_ff[g];                                           // [R16]
        ls_sense_ff <= ls_sync_ff[g];                                           // [R16]
        hs_cnt_ff   <= !hs_sync_ff[g] ? '0 :                                    // [R26]
                       (hs_cnt_ff < CNT_W'(DEBOUNCE_CYCLES)) ? hs_cnt_ff + 1'b1 : hs_cnt_ff;
        ls_cnt_ff   <= !ls_sync_ff[g] ? '0 :                                    // [R26]
                       (ls_cnt_ff < CNT_W'(DEBOUNCE_CYCLES)) ? ls_cnt_ff + 1'b1 : ls_cnt_ff;
        // Status is sticky; no clear port exists at this level
        hs_stat_ff  <= hs_stat_ff | (hs_cnt_ff == CNT_W'(DEBOUNCE_CYCLES));     // [R17]
        ls_stat_ff  <= ls_stat_ff | (ls_cnt_ff == CNT_W'(DEBOUNCE_CYCLES));     // [R17]
      end
    end

    assign run_setpoint_code[g]     = run_ff;
    assign standby_setpoint_code[g] = stby_ff;
    assign sleep_setpoint_code[g]   = slp_ff;
    assign hs_limit_sense[g]        = hs_sense_ff;
    assign ls_limit_sense[g]        = ls_sense_ff;
    assign hs_limit_status[g]       = hs_stat_ff;
    assign ls_limit_status[g]       = ls_stat_ff;
    assign drive[g].mode            = mode_ff;
    assign drive[g].switching       = (mode_ff != MODE_OFF);                    // [R4] [R6]
    assign drive[g].discharge       = (mode_ff == MODE_OFF);                    // [R4]
    assign drive[g].scaling_ref     = scale_on;                                 // [R2]
    assign drive[g].soft_start_ref  = ~scale_on;                                // [R2]
    // Fixed-reference table saturates at index seven
    assign drive[g].target_code     = (!scale_on && target > FIXED_TOP) ? FIXED_TOP
                                                                        : target; // [R22]
    assign drive[g].ramp_code       = ramp_ff;
    assign drive[g].hs_gate_off     = hs_off_ff;
    assign drive[g].ls_gate_off     = ls_off_ff;
  end
endmodule
`default_nettype wire

// ==== shared/bmvc_pkg.sv ====
// Shared constants and types for the buck mode and voltage control block
`default_nettype none
package bmvc_pkg;
  localparam int unsigned CODE_W        = 6;
  localparam int unsigned NUM_BUCKS     = 2;
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned DEBOUNCE_US   = 8000;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned STEP_FAST_NS  = 2000;
  localparam int unsigned STEP_SLOW_NS  = 4000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned STEP_FAST_CYC = STEP_FAST_NS / CLK_PERIOD_NS;
  localparam int unsigned STEP_SLOW_CYC = STEP_SLOW_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 21;
  localparam logic [5:0]  CODE_RST      = 6'h00;
  localparam logic [5:0]  FIXED_TOP     = 6'h07;

  // Power state of the whole device
  typedef enum logic [2:0] {
    PS_REGS_OFF,
    PS_RUN,
    PS_STANDBY,
    PS_SLEEP
  } bmvc_pstate_t;

  // Operating mode delivered to the analog converter
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_ADAPTIVE,
    MODE_FPWM,
    MODE_LOW_POWER
  } bmvc_mode_t;

  // Control bits of one converter
  typedef struct packed {
    logic buck_enable;
    logic buck_on_in_standby;
    logic buck_on_in_sleep;
    logic buck_low_power_request;
    logic buck_force_pwm;
    logic scaling_step_rate;
    logic pwm_during_falling_ramp;
  } bmvc_ctrl_t;

  // Host write of the set-point fields
  typedef struct packed {
    logic       run_we;
    logic       standby_we;
    logic       sleep_we;
    logic [5:0] data;
  } bmvc_spwr_t;

  // Drive of one converter's analog section
  typedef struct packed {
    bmvc_mode_t mode;
    logic       switching;
    logic       discharge;
    logic       scaling_ref;
    logic       soft_start_ref;
    logic [5:0] target_code;
    logic [5:0] ramp_code;
    logic       hs_gate_off;
    logic       ls_gate_off;
  } bmvc_drive_t;
endpackage
`default_nettype wire

// ==== tb/bmvc_host.sv ====
// Host model that issues set-point writes to both converters
`default_nettype none
module bmvc_host (
  input  wire logic                       core_clk,
  input  wire logic                       go,
  input  wire logic [2:0]                 we,
  input  wire logic [5:0]                 data,
  output var  bmvc_pkg::bmvc_spwr_t [1:0] setpoint_write
);
  import bmvc_pkg::*;
  // One-cycle strobe; go against a read-only field is raised only on purpose
  always_ff @(posedge core_clk) begin
    setpoint_write <= go ? {2{we, data}} : '0;
  end
endmodule
`default_nettype wire

// ==== tb/bmvc_checker.sv ====
// Port assertions for the buck mode and voltage control block
`default_nettype none
module bmvc_checker #(
  parameter int unsigned DEBOUNCE_CYCLES = bmvc_pkg::DEBOUNCE_CYC
) (
  input wire logic                       core_clk,
  input wire logic                       nrst,
  input wire bmvc_pkg::bmvc_pstate_t     power_state,
  input wire logic                       processor_reset_out,
  input wire logic [1:0]                 scaling_disable_fuse,
  input wire bmvc_pkg::bmvc_ctrl_t [1:0] ctrl,
  input wire bmvc_pkg::bmvc_spwr_t [1:0] setpoint_write,
  input wire logic [1:0]                 hs_over_limit,
  input wire logic [1:0][5:0]            run_setpoint_code,
  input wire bmvc_pkg::bmvc_drive_t [1:0] drive,
  input wire logic [1:0]                 hs_limit_sense,
  input wire logic [1:0]                 hs_limit_status
);
  import bmvc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Cycles the sense bit has stood high without a break
  logic [20:0] sense_run_ff;
  always_ff @(posedge core_clk) begin
    if (!nrst || !hs_limit_sense[0]) sense_run_ff <= '0;
    else sense_run_ff <= sense_run_ff + 21'h000001;
  end
  ////////////////////////////////////////////////////////////
  property p_off; !ctrl[0].buck_enable |=> drive[0].mode == MODE_OFF; endproperty
  a_off: assert property (p_off) else $error("mode not off");
  property p_fpwm; power_state == PS_RUN && ctrl[0].buck_enable && ctrl[0].buck_force_pwm
    |=> drive[0].mode == MODE_FPWM; endproperty
  a_fpwm: assert property (p_fpwm) else $error("mode not forced pwm");
  property p_stby; power_state == PS_STANDBY && !ctrl[0].buck_on_in_standby
    |=> drive[0].mode == MODE_OFF; endproperty
  a_stby: assert property (p_stby) else $error("standby gate ignored");
  property p_slp; power_state == PS_SLEEP && !ctrl[0].buck_on_in_sleep
    |=> drive[0].mode == MODE_OFF; endproperty
  a_slp: assert property (p_slp) else $error("sleep gate ignored");
  property p_sense; hs_over_limit[0] [*4] |-> hs_limit_sense[0]; endproperty
  a_sense: assert property (p_sense) else $error("sense bit late");
  property p_stat; $rose(hs_limit_status[0]) |-> 32'(sense_run_ff) >= DEBOUNCE_CYCLES - 2;
  endproperty
  a_stat: assert property (p_stat) else $error("status before debounce");
  property p_ro; scaling_disable_fuse[1] && power_state != PS_RUN
    |=> $stable(run_setpoint_code[1]); endproperty
  a_ro: assert property (p_ro) else $error("read-only field changed");
  property p_wr; processor_reset_out [*3] ##0 (setpoint_write[0].run_we
    && !scaling_disable_fuse[0] && power_state == PS_STANDBY)
    |=> run_setpoint_code[0] == $past(setpoint_write[0].data); endproperty
  a_wr: assert property (p_wr) else $error("host write lost");
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench for the buck mode and voltage control block
`default_nettype none
module testbench;
  import bmvc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk = 1'b0;
  logic              nrst = 1'b0;
  bmvc_pstate_t      power_state = PS_REGS_OFF;
  logic              processor_reset_out = 1'b0;
  logic [1:0]        scaling_disable_fuse = 2'h2;
  logic [1:0][5:0]   fused_setpoint_code = {6'h2A, 6'h15};
  bmvc_ctrl_t [1:0]  ctrl = '0;
  bmvc_spwr_t [1:0]  setpoint_write;
  logic [1:0]        hs_over_limit = 2'h0;
  logic [1:0]        ls_over_limit = 2'h0;
  logic [1:0]        cycle_start = 2'h0;
  logic [1:0][5:0]   run_setpoint_code;
  logic [1:0][5:0]   standby_setpoint_code;
  logic [1:0][5:0]   sleep_setpoint_code;
  bmvc_drive_t [1:0] drive;
  logic [1:0]        hs_limit_sense;
  logic [1:0]        ls_limit_sense;
  logic [1:0]        hs_limit_status;
  logic [1:0]        ls_limit_status;
  logic              host_go = 1'b0;
  logic [5:0]        host_data = 6'h00;
  int                error_cnt;
  int                checks;
  always #2.5 core_clk = ~core_clk;
  // Debounce shortened to 20 cycles so the fault tests stay short
  bmvc_top #(.DEBOUNCE_CYCLES(20)) i_bmvc_top (.core_clk, .nrst, .power_state,
    .processor_reset_out, .scaling_disable_fuse, .fused_setpoint_code, .ctrl,
    .setpoint_write, .hs_over_limit, .ls_over_limit, .cycle_start, .run_setpoint_code,
    .standby_setpoint_code, .sleep_setpoint_code, .drive, .hs_limit_sense,
    .ls_limit_sense, .hs_limit_status, .ls_limit_status);
  bmvc_host i_bmvc_host (.core_clk, .go(host_go), .we(3'h7), .data(host_data),
    .setpoint_write);
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string what, input logic [5:0] seen, input logic [5:0] e);
    checks++;
    if (seen !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic host_wr(input logic [5:0] d);
    host_go <= 1'b1;
    host_data <= d;
    cyc(1);
    host_go <= 1'b0;
    cyc(2);
  endtask
  function automatic bmvc_mode_t exp_mode(input bmvc_pstate_t s, input logic [4:0] b);
    if (!b[4] || (s == PS_STANDBY && !b[3]) || (s == PS_SLEEP && !b[2])) return MODE_OFF;
    if (b[0]) return MODE_FPWM;
    if (b[1] && s != PS_RUN) return MODE_LOW_POWER;
    return MODE_ADAPTIVE;
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic t_startup;
    chk("mode after reset", 6'(drive[0].mode), 6'(MODE_OFF));
    chk("code after reset", run_setpoint_code[0], CODE_RST);
    power_state <= PS_RUN;
    cyc(3);
    for (int b = 0; b < 2; b++) begin
      chk("run code", run_setpoint_code[b], fused_setpoint_code[b]);
      chk("standby code", standby_setpoint_code[b], fused_setpoint_code[b]);
      chk("sleep code", sleep_setpoint_code[b], fused_setpoint_code[b]);
      chk("scaling ref", 6'(drive[b].scaling_ref), 6'(!scaling_disable_fuse[b]));
    end
    chk("fixed clamp", drive[1].target_code, FIXED_TOP);
    $display("startup test done");
  endtask
  task automatic t_modes;
    bmvc_mode_t m;
    for (int s = 1; s < 4; s++) begin
      for (int b = 0; b < 32; b++) begin
        power_state <= bmvc_pstate_t'(s);
        ctrl <= {2{5'(b), 2'b00}};
        cyc(2);
        m = exp_mode(bmvc_pstate_t'(s), 5'(b));
        chk("mode buck0", 6'(drive[0].mode), 6'(m));
        chk("mode buck1", 6'(drive[1].mode), 6'(m));
        chk("discharge", 6'(drive[0].discharge), 6'(m == MODE_OFF));
      end
    end
    $display("mode test done");
  endtask
  task automatic t_writes;
    power_state <= PS_STANDBY;
    ctrl <= '0;
    host_wr(6'h3F);
    chk("write before release", standby_setpoint_code[0], 6'h15);
    processor_reset_out <= 1'b1;
    cyc(3);
    host_wr(6'h3F);
    chk("run write", run_setpoint_code[0], 6'h3F);
    chk("sleep write", sleep_setpoint_code[0], 6'h3F);
    chk("standby target", drive[0].target_code, 6'h3F);
    chk("read-only field", standby_setpoint_code[1], 6'h2A);
    $display("write test done");
  endtask
  task automatic t_limits;
    int i;
    hs_over_limit <= 2'h1;
    ls_over_limit <= 2'h2;
    cyc(4);
    chk("hs sense", 6'(hs_limit_sense[0]), 6'h01);
    chk("ls sense", 6'(ls_limit_sense[1]), 6'h01);
    chk("gate off", 6'(drive[0].hs_gate_off), 6'h01);
    cyc(6);
    hs_over_limit <= 2'h0;
    ls_over_limit <= 2'h0;
    cyc(5);
    cycle_start <= 2'h3;
    cyc(4);
    cycle_start <= 2'h0;
    chk("gate released", 6'(drive[0].hs_gate_off), 6'h00);
    hs_over_limit <= 2'h1;
    ls_over_limit <= 2'h2;
    cyc(15);
    chk("status early", 6'(hs_limit_status[0]), 6'h00);
    for (i = 0; i < 40 && hs_limit_status[0] !== 1'b1; i++) cyc(1);
    if (i == 40) begin
      error_cnt++;
      test_done;
    end
    chk("status", 6'({hs_limit_status[0], ls_limit_status[1]}), 6'h03);
    $display("limit test done");
  endtask
  task automatic t_ramp;
    int i;
    for (i = 0; i < 30000 && drive[0].ramp_code !== 6'h3F; i++) cyc(1);
    if (i == 30000) begin
      error_cnt++;
      test_done;
    end
    // Enable, on in standby, forced PWM on falling ramp
    ctrl <= {2{7'h61}};
    cyc(2);
    chk("default mode", 6'(drive[0].mode), 6'(MODE_ADAPTIVE));
    chk("switching", 6'(drive[0].switching), 6'h01);
    chk("no soft start", 6'(drive[0].soft_start_ref), 6'h00);
    host_wr(6'h3D);
    chk("new target", drive[0].target_code, 6'h3D);
    cyc(1);
    chk("falling ramp pwm", 6'(drive[0].mode), 6'(MODE_FPWM));
    cyc(398);
    chk("ramp holds", drive[0].ramp_code, 6'h3F);
    cyc(1);
    chk("ramp steps", drive[0].ramp_code, 6'h3E);
    $display("ramp test done");
  endtask
  initial begin
    cyc(20);
    nrst <= 1'b1;
    cyc(1);
    t_startup;
    t_modes;
    t_writes;
    t_limits;
    t_ramp;
    test_done;
  end
endmodule
bind bmvc_top bmvc_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_bmvc_checker (.core_clk,
  .nrst, .power_state, .processor_reset_out, .scaling_disable_fuse, .ctrl, .setpoint_write,
  .hs_over_limit, .run_setpoint_code, .drive, .hs_limit_sense, .hs_limit_status);
`default_nettype wire
